//--- core/irq_pkg.sv
package irq_pkg;
	// program counter width and vector addresses; fixed priority follows list order
	localparam int          PC_W          = 13;
	localparam logic [12:0] VEC_SERIAL    = 13'h0010;
	localparam logic [12:0] VEC_COMBINED  = 13'h0014;
	localparam logic [12:0] VEC_LOW_SUP   = 13'h0018;
	// register offsets (byte addresses, word aligned)
	localparam logic [3:0]  OFS_CTRL      = 4'h0;
	localparam logic [3:0]  OFS_FLAGS     = 4'h4;
	localparam logic [3:0]  OFS_STATUS    = 4'h8;
	// control register field positions
	localparam int          B_GLOBAL_EN   = 0;
	localparam int          B_SERIAL_EN   = 1;
	localparam int          B_COMB_EN     = 2;
	localparam int          B_CONV_EN     = 3;
	localparam int          B_NVW_EN      = 4;
	localparam int          B_LOW_EN      = 5;
	// flag register field positions
	localparam int          B_SERIAL_F    = 0;
	localparam int          B_COMB_F      = 1;
	localparam int          B_CONV_F      = 2;
	localparam int          B_NVW_F       = 3;
	localparam int          B_LOW_F       = 4;
	localparam int          NFLAG         = 5;
	localparam logic [5:0]  CTRL_RST      = 6'h00;
	localparam logic [4:0]  FLAGS_RST     = 5'h00;
	// selection codes of the arbiter
	typedef enum logic [1:0] {
		SEL_NONE     = 2'b00,
		SEL_SERIAL   = 2'b01,
		SEL_COMBINED = 2'b10,
		SEL_LOW_SUP  = 2'b11
	} sel_t;
endpackage : irq_pkg

//--- core/req_flag.sv
`timescale 1ns/1ps
`default_nettype none
// one sticky request flag: hardware set beats any clear
module req_flag (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			flag_o <= 1'b0;
		else if (set_i)
			flag_o <= 1'b1;
		else if (clr_i)
			flag_o <= 1'b0;
	end
endmodule : req_flag
`default_nettype wire

//--- core/irq_logic.sv
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: serial flag sets on byte done or two-wire address match.
// R2: serial vector needs flag, global enable, serial enable, stack not full.
// R3: taking serial interrupt clears serial flag and global enable.
// R4: combined flag sets when converter or write-done flag becomes set.
// R5: taking combined interrupt clears combined flag and global enable only.
// R6: software clears converter and write-done flags itself.
// R7: converter flag sets per conversion; vectors with global, converter, combined enables.
// R8: write-done flag sets at write end; vectors with global, write, combined enables.
// R9: low-supply flag sets on detector report; vectors with global and low enables.
// R10: taking low-supply interrupt clears its flag and global enable.
// R11: in sleep or idle, any flag rising edge wakes, enables ignored.
// R12: flag already high on sleep entry gives no wake-up.
// R13: set flags stay set until serviced or cleared by software.
// R14: only the program counter is pushed when an interrupt is taken.
// R15: interrupt return pops program counter and sets global enable.
// R16: plain return pops program counter and leaves global enable low.
// R17: service routines should avoid calls to protect a nearly full stack.
// R18: taking an interrupt loads the program counter with the vector.
// R19: global enable low blocks all interrupts; flags still record.
// R20: one interrupt per cycle by fixed priority serial, combined, low-supply.
module irq_logic (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// avalon-mm slave
	input  wire logic [3:0]             address_i,
	input  wire logic                   read_i,
	input  wire logic                   write_i,
	input  wire logic [31:0]            writedata_i,
	output logic      [31:0]            readdata_o,
	output logic                        waitrequest_o,
	output logic      [1:0]             response_o,
	// event sources (same clock domain)
	input  wire logic                   serial_byte_done_i,
	input  wire logic                   serial_addr_match_i,
	input  wire logic                   converter_done_i,
	input  wire logic                   nv_write_end_i,
	input  wire logic                   low_supply_i,
	// core side
	input  wire logic                   sleep_i,
	input  wire logic                   stack_full_i,
	input  wire logic                   return_from_irq_instr_i,
	input  wire logic                   plain_return_instr_i,
	input  wire logic [irq_pkg::PC_W-1:0] pc_i,
	output logic                        push_o,
	output logic      [irq_pkg::PC_W-1:0] push_pc_o,
	output logic                        load_pc_o,
	output logic      [irq_pkg::PC_W-1:0] vector_o,
	output logic                        wakeup_o,
	output logic                        global_irq_enable_o
);
	import irq_pkg::*;

	logic [5:0]       ctrl_ff;
	logic [NFLAG-1:0] flag;
	logic [NFLAG-1:0] prev_flag_ff;
	logic             low_prev_ff;
	logic             conv_prev_ff;
	logic             nvw_prev_ff;
	logic             ack_ff;
	logic [31:0]      nxt_readdata;
	logic             nxt_global;
	sel_t             sel;

	// enable and flag bit names
	wire global_irq_enable        = ctrl_ff[B_GLOBAL_EN];
	wire serial_module_irq_enable = ctrl_ff[B_SERIAL_EN];
	wire combined_irq_enable      = ctrl_ff[B_COMB_EN];
	wire converter_irq_enable     = ctrl_ff[B_CONV_EN];
	wire nv_write_irq_enable      = ctrl_ff[B_NVW_EN];
	wire low_supply_irq_enable    = ctrl_ff[B_LOW_EN];
	wire serial_module_req_flag   = flag[B_SERIAL_F];
	wire combined_req_flag        = flag[B_COMB_F];
	wire converter_done_flag      = flag[B_CONV_F];
	wire nv_write_done_flag       = flag[B_NVW_F];
	wire low_supply_req_flag      = flag[B_LOW_F];

	// bus decode: one-cycle wait then acknowledge
	wire access   = (read_i | write_i) & ~ack_ff;
	wire hit_ctrl = (address_i == OFS_CTRL);
	wire hit_flag = (address_i == OFS_FLAGS);
	wire hit_stat = (address_i == OFS_STATUS);
	wire mapped   = hit_ctrl | hit_flag | hit_stat;
	wire wr_ctrl  = write_i & ack_ff & hit_ctrl;
	wire wr_flag  = write_i & ack_ff & hit_flag;
	// software clears flags by writing one to them
	wire [NFLAG-1:0] sw_clr = wr_flag ? writedata_i[NFLAG-1:0] : '0;

	// event sets
	wire conv_rise = converter_done_flag & ~conv_prev_ff;
	wire nvw_rise  = nv_write_done_flag & ~nvw_prev_ff;
	wire low_rise  = low_supply_i & ~low_prev_ff;
	wire set_serial = serial_byte_done_i | serial_addr_match_i;         // [R1]
	wire set_comb   = conv_rise | nvw_rise;                             // [R4]

	// request qualification, stack and global gate
	wire can_take  = global_irq_enable & ~stack_full_i;                 // [R19]
	wire req_ser   = serial_module_req_flag & serial_module_irq_enable; // [R2]
	wire req_comb  = combined_req_flag & combined_irq_enable
		& ((converter_done_flag & converter_irq_enable)                 // [R7]
		| (nv_write_done_flag & nv_write_irq_enable));                  // [R8]
	wire req_low   = low_supply_req_flag & low_supply_irq_enable;       // [R9]

	// fixed priority: one taken per cycle
	assign sel = !can_take ? SEL_NONE :
		req_ser  ? SEL_SERIAL :
		req_comb ? SEL_COMBINED :
		req_low  ? SEL_LOW_SUP : SEL_NONE;                              // [R20]
	wire take = (sel != SEL_NONE);

	// hardware clears on service; members of combined untouched
	wire [NFLAG-1:0] hw_clr;
	assign hw_clr[B_SERIAL_F] = (sel == SEL_SERIAL);                    // [R3]
	assign hw_clr[B_COMB_F]   = (sel == SEL_COMBINED);                  // [R5]
	assign hw_clr[B_CONV_F]   = 1'b0;                                   // [R6]
	assign hw_clr[B_NVW_F]    = 1'b0;
	assign hw_clr[B_LOW_F]    = (sel == SEL_LOW_SUP);                   // [R10]

	wire [NFLAG-1:0] hw_set;
	assign hw_set[B_SERIAL_F] = set_serial;
	assign hw_set[B_COMB_F]   = set_comb;
	assign hw_set[B_CONV_F]   = converter_done_i;                       // [R7]
	assign hw_set[B_NVW_F]    = nv_write_end_i;                         // [R8]
	assign hw_set[B_LOW_F]    = low_rise;                               // [R9]

	// sticky flags, one instance per request
	genvar gi;
	for (gi = 0; gi < NFLAG; gi++) begin : g_flag
		req_flag u_flag (
			.clk_i  (clk_i),
			.rst_i  (rst_i),
			.set_i  (hw_set[gi]),
			.clr_i  (hw_clr[gi] | sw_clr[gi]),                          // [R13]
			.flag_o (flag[gi])
		);
	end

	// global enable: cleared on take, set by interrupt return or a control register write
	always_comb begin
		nxt_global = global_irq_enable;
		if (wr_ctrl)
			nxt_global = writedata_i[B_GLOBAL_EN];
		if (return_from_irq_instr_i)
			nxt_global = 1'b1;                                          // [R15]
		if (take)
			nxt_global = 1'b0;                                          // [R3] [R5] [R10]
	end
	// plain return leaves global enable as is [R16]

	// control register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			ctrl_ff <= CTRL_RST;
		else begin
			if (wr_ctrl)
				ctrl_ff[5:1] <= writedata_i[5:1];
			ctrl_ff[B_GLOBAL_EN] <= nxt_global;
		end
	end

	// edge history for member and detector sets and wake-up
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_flag_ff <= FLAGS_RST;
			conv_prev_ff <= 1'b0;
			nvw_prev_ff  <= 1'b0;
			low_prev_ff  <= 1'b0;
		end else begin
			prev_flag_ff <= flag;
			conv_prev_ff <= converter_done_flag;
			nvw_prev_ff  <= nv_write_done_flag;
			low_prev_ff  <= low_supply_i;
		end
	end

	// wake-up on any flag rising edge, enables ignored
	wire any_rise = |(flag & ~prev_flag_ff);                            // [R11] [R12]

	// readback mux
	always_comb begin
		nxt_readdata = 32'h0000_0000;
		if (hit_ctrl)
			nxt_readdata[5:0] = ctrl_ff;
		else if (hit_flag)
			nxt_readdata[NFLAG-1:0] = flag;
		else if (hit_stat)
			nxt_readdata[2:0] = {stack_full_i, sleep_i, global_irq_enable};
	end

	// core outputs and bus answer registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			push_o              <= 1'b0;
			push_pc_o           <= '0;
			load_pc_o           <= 1'b0;
			vector_o            <= '0;
			wakeup_o            <= 1'b0;
			global_irq_enable_o <= 1'b0;
			ack_ff              <= 1'b0;
			waitrequest_o       <= 1'b1;
			readdata_o          <= 32'h0000_0000;
			response_o          <= 2'h0;
		end else begin
			push_o              <= take;                                // [R14]
			push_pc_o           <= pc_i;                                // [R14]
			load_pc_o           <= take;                                // [R18]
			vector_o            <= (sel == SEL_SERIAL) ? VEC_SERIAL :
				(sel == SEL_COMBINED) ? VEC_COMBINED : VEC_LOW_SUP;     // [R18]
			wakeup_o            <= sleep_i & any_rise;                  // [R11]
			global_irq_enable_o <= nxt_global;
			ack_ff              <= access;
			waitrequest_o       <= ~access;
			readdata_o          <= nxt_readdata;
			response_o          <= mapped ? 2'h0 : 2'h2;
		end
	end

	// taken interrupt always clears global enable next cycle
	global_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> !global_irq_enable) else $error("global enable not cleared on take"); // [R3]
	// nothing taken while global enable low
	no_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!global_irq_enable |-> !take) else $error("interrupt taken with global enable low"); // [R19]
	// serial flag cleared after service unless set again
	serial_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sel == SEL_SERIAL) && !set_serial |=> !serial_module_req_flag) else $error("serial flag kept"); // [R3]
	// converter member of combined survives its service
	member_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sel == SEL_COMBINED) && converter_done_flag && !sw_clr[B_CONV_F] |=> converter_done_flag)
		else $error("converter flag lost on service"); // [R5]
	// low-supply flag cleared after service
	low_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sel == SEL_LOW_SUP) && !low_rise |=> !low_supply_req_flag) else $error("low flag kept"); // [R10]
	// interrupt return raises global enable
	return_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
		return_from_irq_instr_i && !take |=> global_irq_enable) else $error("return did not enable"); // [R15]
	// plain return with global low keeps it low
	plain_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		plain_return_instr_i && !return_from_irq_instr_i && !wr_ctrl && !global_irq_enable
		|=> !global_irq_enable) else $error("plain return changed enable"); // [R16]
	// push and vector load appear together one cycle after take
	push_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> push_o && load_pc_o && push_pc_o == $past(pc_i)) else $error("push or load missing"); // [R14]
	// converter flag rising edge sets combined flag next cycle
	comb_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_rise |=> combined_req_flag) else $error("combined flag not set"); // [R4]
	// wake-up follows a flag rise in sleep
	wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sleep_i && $rose(serial_module_req_flag) |=> wakeup_o) else $error("no wake-up on rise"); // [R11]

	// a serial byte or address event always lands in its flag
	serial_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		set_serial |=> serial_module_req_flag) else $error("serial flag not set");
	// a full stack blocks every take
	stack_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		stack_full_i |-> !take) else $error("interrupt taken with stack full");
	// serial take loads the serial vector
	serial_vec_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		(sel == SEL_SERIAL) |=> vector_o == VEC_SERIAL) else $error("wrong serial vector");
	// combined take loads the combined vector
	comb_vec_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		(sel == SEL_COMBINED) |=> vector_o == VEC_COMBINED) else $error("wrong combined vector");
	// low-supply take loads the low-supply vector
	low_vec_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		(sel == SEL_LOW_SUP) |=> vector_o == VEC_LOW_SUP) else $error("wrong low-supply vector");
	// end of conversion sets the converter flag
	conv_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		converter_done_i |=> converter_done_flag) else $error("converter flag not set");
	// end of a memory write sets the write-done flag
	nvw_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		nv_write_end_i |=> nv_write_done_flag) else $error("write-done flag not set");
	// detector rising edge sets the low-supply flag
	low_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		low_rise |=> low_supply_req_flag) else $error("low-supply flag not set");
	// serial request beats the others when it may be taken
	serial_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
		can_take && req_ser |-> sel == SEL_SERIAL) else $error("priority order broken");
	// a set flag holds while nothing clears it
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		serial_module_req_flag && !hw_clr[B_SERIAL_F] && !sw_clr[B_SERIAL_F] |=> serial_module_req_flag)
		else $error("serial flag dropped");
	// no wake-up pulse outside sleep
	sleep_only_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		!sleep_i |=> !wakeup_o) else $error("wake-up while awake");
	// no wake-up pulse without a flag rising edge
	no_rise_wake_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		!any_rise |=> !wakeup_o) else $error("wake-up without rising flag");
	// write-done member also survives combined service
	write_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		(sel == SEL_COMBINED) && nv_write_done_flag && !sw_clr[B_NVW_F] |=> nv_write_done_flag)
		else $error("write-done flag lost on service");
	// write-done rising edge sets the combined flag
	nvw_comb_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		nvw_rise |=> combined_req_flag) else $error("combined flag not set by write");
	// an accepted access is answered on the next edge
	bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		access |=> !waitrequest_o) else $error("bus access not answered");
	// the answer stands for one cycle only
	answer_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!waitrequest_o |=> waitrequest_o) else $error("waitrequest low too long");
endmodule : irq_logic
`default_nettype wire

//--- testbench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural core: program counter and a small return stack
module core_model #(
	parameter int DEPTH = 2
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       push_i,
	input  wire logic [irq_pkg::PC_W-1:0]   push_pc_i,
	input  wire logic                       load_pc_i,
	input  wire logic [irq_pkg::PC_W-1:0]   vector_i,
	input  wire logic                       irq_return_req_i,
	input  wire logic                       plain_return_req_i,
	output logic                            irq_return_o,
	output logic                            plain_return_o,
	output logic      [irq_pkg::PC_W-1:0]   pc_o,
	output logic                            stack_full_o
);
	import irq_pkg::*;
	logic [PC_W-1:0] stack_ff [DEPTH];
	int              depth_ff;
	// pc holds still between jumps so the stacked value is predictable
	// no subroutine calls are modelled, the stack only holds interrupt returns
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_o     <= 13'h0100;
			depth_ff <= 0;
			irq_return_o   <= 1'b0;
			plain_return_o <= 1'b0;
		end else begin
			irq_return_o   <= irq_return_req_i;
			plain_return_o <= plain_return_req_i;
			if (push_i && depth_ff < DEPTH) begin
				stack_ff[depth_ff] <= push_pc_i;
				depth_ff           <= depth_ff + 1;
			end
			if (load_pc_i) begin
				pc_o <= vector_i;
			end else if ((irq_return_req_i || plain_return_req_i) && depth_ff > 0) begin
				pc_o     <= stack_ff[depth_ff-1];
				depth_ff <= depth_ff - 1;
			end
		end
	end
	// full stack refuses further interrupts
	assign stack_full_o = (depth_ff == DEPTH);
endmodule : core_model
`default_nettype wire

//--- testbench/mcu_interrupt_request_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_request_logic_tb;
	import irq_pkg::*;
	logic clk_i = 0, rst_i = 1, read_i = 0, write_i = 0, sleep_i = 0, low_i = 0;
	logic full_force = 0, irq_return_req = 0, plain_return_req = 0, irq_return, plain_return, full, push_o;
	logic load_pc_o, wakeup_o, waitrequest_o, gie;
	logic [3:0]      address_i = 4'h0, ev = 4'h0;
	logic [31:0]     writedata_i = 32'h0, readdata_o, rd;
	logic [1:0]      response_o, rsp;
	logic [PC_W-1:0] pc, push_pc, vector_o;
	int              mismatches = 0, comparisons = 0, wakes = 0;
	// clock and wake-up pulse counter
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (wakeup_o === 1'b1) wakes <= wakes + 1;
	irq_logic uut (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .response_o(response_o),
		.serial_byte_done_i(ev[0]), .serial_addr_match_i(ev[1]), .converter_done_i(ev[2]), .nv_write_end_i(ev[3]),
		.low_supply_i(low_i), .sleep_i(sleep_i), .stack_full_i(full | full_force),
		.return_from_irq_instr_i(irq_return), .plain_return_instr_i(plain_return), .pc_i(pc), .push_o(push_o),
		.push_pc_o(push_pc), .load_pc_o(load_pc_o), .vector_o(vector_o), .wakeup_o(wakeup_o),
		.global_irq_enable_o(gie));
	core_model core (.clk_i(clk_i), .rst_i(rst_i), .push_i(push_o), .push_pc_i(push_pc), .load_pc_i(load_pc_o),
		.vector_i(vector_o), .irq_return_req_i(irq_return_req), .plain_return_req_i(plain_return_req),
		.irq_return_o(irq_return), .plain_return_o(plain_return), .pc_o(pc), .stack_full_o(full));
	// comparison and verdict
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		address_i <= a;
		writedata_i <= d;
		write_i <= wr;
		read_i <= !wr;
		do begin @(posedge clk_i); n++; end while (waitrequest_o !== 1'b0 && n < 20);
		rd = readdata_o;
		rsp = response_o;
		if (n >= 20) check("bus answer", 32'h0, 32'h1);
		write_i <= 1'b0;
		read_i <= 1'b0;
	endtask : bus
	task automatic pulse(input int i);
		@(posedge clk_i);
		ev[i] <= 1'b1;
		@(posedge clk_i);
		ev[i] <= 1'b0;
	endtask : pulse
	// wait for a taken interrupt and check its vector and push
	task automatic take(input logic [PC_W-1:0] v);
		int n;
		n = 0;
		do begin @(posedge clk_i); n++; end while (load_pc_o !== 1'b1 && n < 10);
		check("taken", {31'h0, load_pc_o}, 32'h1);
		check("push", {31'h0, push_o}, 32'h1);
		check("vector", {19'h0, vector_o}, {19'h0, v});
	endtask : take
	task automatic none();
		logic hit;
		hit = 1'b0;
		repeat (8) begin @(posedge clk_i); hit |= (load_pc_o === 1'b1); end
		check("no take", {31'h0, hit}, 32'h0);
	endtask : none
	// core return: interrupt return or plain return, then enable and pc checks
	task automatic do_return(input logic use_irq_return);
		@(posedge clk_i);
		if (use_irq_return) irq_return_req <= 1'b1;
		else plain_return_req <= 1'b1;
		@(posedge clk_i);
		irq_return_req <= 1'b0;
		plain_return_req <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("global enable", {31'h0, gie}, {31'h0, use_irq_return});
		check("popped pc", {19'h0, pc}, 32'h100);
	endtask : do_return
	initial begin
		#(4000 * 100);
		mismatches++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, OFS_CTRL, 0);    check("ctrl reset", rd, 32'h0);
		bus(0, 4'hC, 0);        check("unmapped data", rd, 32'h0);
		check("unmapped resp", {30'h0, rsp}, 32'h2);
		pulse(0);               none();
		bus(0, OFS_FLAGS, 0);   check("serial flag", rd, 32'h01);
		bus(1, OFS_CTRL, 32'h03); take(VEC_SERIAL);
		@(posedge clk_i);
		check("pc at vector", {19'h0, pc}, {19'h0, VEC_SERIAL});
		check("enable cleared", {31'h0, gie}, 32'h0);
		bus(0, OFS_FLAGS, 0);   check("serial cleared", rd, 32'h0);
		do_return(1);
		pulse(1);               take(VEC_SERIAL);
		do_return(0);
		bus(1, OFS_CTRL, 32'h0D); pulse(2); take(VEC_COMBINED);
		bus(0, OFS_FLAGS, 0);   check("member kept", rd, 32'h04);
		bus(1, OFS_FLAGS, 32'h04); bus(0, OFS_FLAGS, 0);
		check("member cleared", rd, 32'h0);
		do_return(1);
		bus(1, OFS_CTRL, 32'h15); pulse(3); take(VEC_COMBINED);
		bus(0, OFS_FLAGS, 0);   check("write flag kept", rd, 32'h08);
		do_return(1);
		bus(1, OFS_CTRL, 32'h09); bus(1, OFS_FLAGS, 32'h1F); pulse(2); none();
		bus(1, OFS_FLAGS, 32'h1F);
		bus(1, OFS_CTRL, 32'h21); low_i <= 1'b1; take(VEC_LOW_SUP);
		bus(0, OFS_FLAGS, 0);   check("low cleared", rd, 32'h0);
		check("low enable off", {31'h0, gie}, 32'h0);
		do_return(1);
		low_i <= 1'b0;
		full_force <= 1'b1;     pulse(0); bus(1, OFS_CTRL, 32'h23); none();
		bus(0, OFS_STATUS, 0);  check("status full", rd, 32'h5);
		full_force <= 1'b0;     take(VEC_SERIAL);
		do_return(1);
		bus(1, OFS_CTRL, 32'h22); pulse(0); low_i <= 1'b1;
		bus(1, OFS_CTRL, 32'h23); take(VEC_SERIAL);
		do_return(1);           take(VEC_LOW_SUP);
		do_return(1);
		bus(1, OFS_CTRL, 0);    bus(1, OFS_FLAGS, 32'h1F);
		sleep_i <= 1'b1;        pulse(0); repeat (3) @(posedge clk_i);
		check("wake on rise", wakes, 1);
		pulse(0);               repeat (3) @(posedge clk_i);
		check("no wake when high", wakes, 1);
		bus(0, OFS_STATUS, 0);  check("status asleep", rd, 32'h2);
		test_done();
	end
endmodule : mcu_interrupt_request_logic_tb
`default_nettype wire
